// ===== ads_regs.vh
// Register map, field positions and frame constants of the analog die
// control block. Included by the design files by bare name.
`ifndef ADS_REGS_VH
`define ADS_REGS_VH

// Register addresses (five-bit address field)
`define ADS_ADDR_W 5
`define ADS_ADDR_OCSUM 5'h02
`define ADS_ADDR_MASK 5'h04
`define ADS_ADDR_STAT 5'h0c

// Interrupt enable mask fields and reset value
`define ADS_MASK_RST 8'h00
`define ADS_MASK_WMASK 8'h3e
`define ADS_BIT_LINE_EVENT_IRQ_ENABLE 5
`define ADS_BIT_HIGH_TEMP_IRQ_ENABLE 4
`define ADS_BIT_LOW_VOLTAGE_IRQ_ENABLE 3
`define ADS_BIT_HIGH_VOLTAGE_IRQ_ENABLE 2
`define ADS_BIT_OVERCURRENT_IRQ_ENABLE 1

// Status register fields
`define ADS_BIT_LINCL 6
`define ADS_BIT_HVDD_OCF 5
`define ADS_BIT_LVF 3
`define ADS_BIT_HVF 2
`define ADS_BIT_HB_OCF 1
`define ADS_BIT_HTF 0

// Sticky flag vector: index of each flag
`define ADS_NFLAG 5
`define ADS_FL_HTF 0
`define ADS_FL_HBOC 1
`define ADS_FL_HVF 2
`define ADS_FL_LVF 3
`define ADS_FL_HVDDOC 4
`define ADS_FLAGS_RST 5'h00

// Summary overcurrent register field
`define ADS_BIT_OCSUM 0

// Frame layout: edges per frame, edge on which parity arrives
`define ADS_CNT_W 5
`define ADS_FRAME_EDGES 5'h10
`define ADS_PARITY_EDGE 5'h07
`define ADS_CNT_OVER 5'h11
`define ADS_TX_RST 16'h0000
`define ADS_BYTE_ZERO 8'h00

// Number of synchronised outside inputs
`define ADS_NSYNC 12
// Idle levels of the synchronised pins: select and reset high, rest low
`define ADS_SYNC_RST 12'h009

`endif

// ===== ads_spi_master.sv
// SPI master model for the analog die serial port.
// Assumes the bench resolves the die's data-out driver into miso.
`timescale 1ns/10ps
`default_nettype none
module ads_spi_master
(
  output logic ss_n,
  output logic sck,
  output logic mosi,
  input wire logic miso
);
  // Idle levels: deselected, clock low
  initial
  begin
    ss_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
  end
  // One frame of n clock pulses, MSB first both ways
  task automatic xfer(input logic [15:0] d, input int n,
    output logic [15:0] q);
    int i;
    begin
      #37.1 ss_n = 1'b0;
      for (i = 0; i < n; i++)
      begin
        // Bench half period 62.5 ns; design needs a few sys_clk per phase
        #62.5 sck = 1'b1;
        mosi = d[15 - (i % 16)];
        #62.5 sck = 1'b0;
        q = {q[14:0], miso};
      end
      #62.5 ss_n = 1'b1;
      mosi = ~mosi; // Released line shows no stale value
      #500;
    end
  endtask
endmodule
`default_nettype wire

// ===== ads_spi_status.v
// Analog die control logic: serial slave port, sticky status flags,
// interrupt enable mask, open-drain interrupt and two-way reset line.
// Assumes sys_clk far faster than the serial clock; all pins are
// sampled through ads_sync before use.
//
// How it works
// - Low-voltage flag sets on condition, clears on write one, reset clears.
// - Clearing low-voltage flag ignored while the condition is present.
// - High-voltage flag sets on condition, clears on write one, reset clears.
// - Clearing high-voltage flag ignored while the condition persists.
// - Read-only summary overcurrent flag set on overcurrent, cleared by reset.
// - Apart from reset, summary flag clears only by writing one to an individual overcurrent flag.
// - Line-event enable bit lets line flag raise interrupt; reset clears.
// - High-temperature enable at mask bit 4 gates its flag; reset clears.
// - Low-voltage enable bit gates low-voltage flag; reset clears.
// - High-voltage enable bit gates high-voltage flag; reset clears.
// - Overcurrent enable at mask bit 1 gates summary flag; reset clears.
// - Open-drain interrupt output signals errors and wake-up events.
// - Reset line is two-way: die pulls it low, and obeys it.
// - Frames are two bytes: address and data in, status and data out.
// - Select falling starts frame, enables output, first bit on rise.
// - Output changes on rising serial clock, input sampled on falling.
// - Frame valid only with exactly 16 sampling edges while selected.
// - Write data committed only on select rising after a valid write.
// - Read data captured when the address parity bit is transferred.
// - Serial output is high impedance while select is high.
// - Address byte holds five address bits and a read/write bit.
// - During a write the old register contents are shifted out.
// - Parity is odd count of ones over direction and address bits.
`timescale 1ns/10ps
`default_nettype none
`include "ads_regs.vh"

module ads_spi_status
(
  input wire sys_clk,
  input wire srst,
  input wire slave_select_n,
  input wire serial_shift_clock,
  input wire mosi,
  output reg miso_out,
  output reg miso_oe,
  output reg irq_n_out,
  output reg irq_n_oe,
  input wire rst_n_in,
  output reg rst_n_out,
  output reg rst_n_oe,
  input wire die_reset_req,
  output reg mcu_reset_seen,
  input wire low_voltage_cond,
  input wire high_voltage_cond,
  input wire hb_overcurrent_cond,
  input wire hvdd_overcurrent_cond,
  input wire high_temp_cond,
  input wire lin_current_limit,
  input wire line_event_flag,
  input wire wake_event,
  output reg [7:0] interrupt_enable_mask
);

  // Synchronised pins
  wire [`ADS_NSYNC-1:0] pins_raw;
  wire [`ADS_NSYNC-1:0] pins_s;
  wire ss_n_s;
  wire sck_s;
  wire mosi_s;
  wire rst_n_s;
  wire [`ADS_NFLAG-1:0] cond_s;
  wire lincl_s;
  wire line_s;
  wire wake_s;

  // Edge detection history
  reg ss_n_d;
  reg sck_d;
  wire ss_fall;
  wire ss_rise;
  wire sck_rise;
  wire sck_fall;

  // Frame state
  reg [`ADS_CNT_W-1:0] edge_cnt;
  reg [15:0] rx_shift;
  reg [15:0] tx_shift;
  reg [`ADS_ADDR_W-1:0] frame_addr;
  reg frame_read;
  reg frame_par_ok;
  wire [15:0] next_rx;
  wire frame_ok;
  wire do_write;
  wire [7:0] wr_data;

  // Status state
  reg [`ADS_NFLAG-1:0] flags;
  wire [`ADS_NFLAG-1:0] next_flags;
  reg [`ADS_NFLAG-1:0] flag_clr;
  reg overcurrent_summary_flag;
  wire clear_all;
  wire irq_active;
  wire [7:0] status_byte;

  // True when an address field selects the given register
  function sel;
    input [`ADS_ADDR_W-1:0] a;
    input [`ADS_ADDR_W-1:0] target;
    begin
      sel = (a == target);
    end
  endfunction

  // Register read decode; unmapped addresses read zero
  function [7:0] reg_read;
    input [`ADS_ADDR_W-1:0] a;
    begin
      reg_read = `ADS_BYTE_ZERO;
      if (sel(a, `ADS_ADDR_MASK))
        reg_read = interrupt_enable_mask;
      else if (sel(a, `ADS_ADDR_STAT))
        reg_read = status_byte;
      else if (sel(a, `ADS_ADDR_OCSUM))
        reg_read[`ADS_BIT_OCSUM] = overcurrent_summary_flag;
    end
  endfunction

  // Gather every outside pin into one synchroniser bank
  assign pins_raw = {wake_event, line_event_flag, lin_current_limit,
                     hvdd_overcurrent_cond, low_voltage_cond,
                     high_voltage_cond, hb_overcurrent_cond,
                     high_temp_cond, rst_n_in, mosi,
                     serial_shift_clock, slave_select_n};

  ads_sync #(.W(`ADS_NSYNC), .RST_VAL(`ADS_SYNC_RST)) u_sync
  (
    .sys_clk(sys_clk),
    .srst(srst),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  assign ss_n_s = pins_s[0];
  assign sck_s = pins_s[1];
  assign mosi_s = pins_s[2];
  assign rst_n_s = pins_s[3];
  assign cond_s = pins_s[8:4];
  assign lincl_s = pins_s[9];
  assign line_s = pins_s[10];
  assign wake_s = pins_s[11];

  // Reset from srst or from the microcontroller side of the line
  assign clear_all = srst | ~rst_n_s;

  // Edges of select; serial clock edges seen only while selected
  assign ss_fall = ss_n_d & ~ss_n_s;
  assign ss_rise = ~ss_n_d & ss_n_s;
  assign sck_rise = ~ss_n_s & ~sck_d & sck_s;
  assign sck_fall = ~ss_n_s & sck_d & ~sck_s;

  // Incoming bits shift in MSB first
  assign next_rx = {rx_shift[14:0], mosi_s};

  // Frame accepted only with exact edge count and good write parity
  assign frame_ok = (edge_cnt == `ADS_FRAME_EDGES);
  assign do_write = ss_rise & frame_ok & ~frame_read & frame_par_ok;
  assign wr_data = rx_shift[7:0];

  // Status byte sent first in every frame
  assign status_byte = {1'b0, lincl_s, flags[`ADS_FL_HVDDOC], 1'b0,
                        flags[`ADS_FL_LVF], flags[`ADS_FL_HVF],
                        flags[`ADS_FL_HBOC], flags[`ADS_FL_HTF]};

  // Edge history registers
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      ss_n_d <= 1'b1;
      sck_d <= 1'b0;
    end
    else
    begin
      ss_n_d <= ss_n_s;
      sck_d <= sck_s;
    end
  end

  // Receive side: count sampling edges, capture address byte
  always @(posedge sys_clk)
  begin
    if (clear_all)
    begin
      edge_cnt <= {`ADS_CNT_W{1'b0}};
      rx_shift <= `ADS_TX_RST;
      frame_addr <= {`ADS_ADDR_W{1'b0}};
      frame_read <= 1'b1;
      frame_par_ok <= 1'b0;
    end
    else if (ss_fall)
    begin
      edge_cnt <= {`ADS_CNT_W{1'b0}};
      frame_read <= 1'b1;
      frame_par_ok <= 1'b0;
    end
    else if (sck_fall)
    begin
      rx_shift <= next_rx;
      if (edge_cnt != `ADS_CNT_OVER)
        edge_cnt <= edge_cnt + 5'h01;
      if (edge_cnt == `ADS_PARITY_EDGE - 5'h01)
      begin
        frame_addr <= next_rx[6:2];
        frame_read <= next_rx[1];
        frame_par_ok <= (next_rx[0] == ^next_rx[6:1]);
      end
    end
  end

  // Transmit side: status byte, then register data captured at parity
  always @(posedge sys_clk)
  begin
    if (clear_all)
    begin
      tx_shift <= `ADS_TX_RST;
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
    end
    else if (ss_fall)
    begin
      tx_shift <= {status_byte, `ADS_BYTE_ZERO};
      miso_oe <= 1'b1;
    end
    else if (ss_n_s)
    begin
      miso_oe <= 1'b0;
    end
    else if (sck_rise)
    begin
      miso_out <= tx_shift[15];
      tx_shift <= {tx_shift[14:0], 1'b0};
    end
    else if (sck_fall && edge_cnt == `ADS_PARITY_EDGE - 5'h01)
    begin
      // Old contents go out, also on a write
      tx_shift[14:7] <= reg_read(next_rx[6:2]);
    end
  end

  // Write-one-to-clear strobes for the sticky flags
  always @*
  begin
    flag_clr = `ADS_FLAGS_RST;
    if (do_write && sel(frame_addr, `ADS_ADDR_STAT))
    begin
      flag_clr[`ADS_FL_HTF] = wr_data[`ADS_BIT_HTF];
      flag_clr[`ADS_FL_HBOC] = wr_data[`ADS_BIT_HB_OCF];
      flag_clr[`ADS_FL_HVF] = wr_data[`ADS_BIT_HVF];
      flag_clr[`ADS_FL_LVF] = wr_data[`ADS_BIT_LVF];
      flag_clr[`ADS_FL_HVDDOC] = wr_data[`ADS_BIT_HVDD_OCF];
    end
  end

  // Sticky flags: a present condition wins over a clear
  genvar f;
  generate
    for (f = 0; f < `ADS_NFLAG; f = f + 1)
    begin : g_flag
      assign next_flags[f] = cond_s[f] | (flags[f] & ~flag_clr[f]);
    end
  endgenerate

  // Flag and summary registers
  always @(posedge sys_clk)
  begin
    if (clear_all)
    begin
      flags <= `ADS_FLAGS_RST;
      overcurrent_summary_flag <= 1'b0;
    end
    else
    begin
      flags <= next_flags;
      if (cond_s[`ADS_FL_HBOC] | cond_s[`ADS_FL_HVDDOC])
        overcurrent_summary_flag <= 1'b1;
      else if (flag_clr[`ADS_FL_HBOC] | flag_clr[`ADS_FL_HVDDOC])
        overcurrent_summary_flag <= 1'b0;
    end
  end

  // Interrupt enable mask, committed at end of a valid write
  always @(posedge sys_clk)
  begin
    if (clear_all)
      interrupt_enable_mask <= `ADS_MASK_RST;
    else if (do_write && sel(frame_addr, `ADS_ADDR_MASK))
      interrupt_enable_mask <= wr_data & `ADS_MASK_WMASK;
  end

  // Any enabled flag, or a wake-up, requests an interrupt
  assign irq_active =
    (line_s & interrupt_enable_mask[`ADS_BIT_LINE_EVENT_IRQ_ENABLE]) |
    (flags[`ADS_FL_HTF] & interrupt_enable_mask[`ADS_BIT_HIGH_TEMP_IRQ_ENABLE]) |
    (flags[`ADS_FL_LVF] & interrupt_enable_mask[`ADS_BIT_LOW_VOLTAGE_IRQ_ENABLE]) |
    (flags[`ADS_FL_HVF] & interrupt_enable_mask[`ADS_BIT_HIGH_VOLTAGE_IRQ_ENABLE]) |
    (overcurrent_summary_flag &
     interrupt_enable_mask[`ADS_BIT_OVERCURRENT_IRQ_ENABLE]) |
    wake_s;

  // Open-drain interrupt and reset drivers
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      irq_n_out <= 1'b0;
      irq_n_oe <= 1'b0;
      rst_n_out <= 1'b0;
      rst_n_oe <= 1'b0;
      mcu_reset_seen <= 1'b0;
    end
    else
    begin
      irq_n_out <= 1'b0;
      irq_n_oe <= irq_active & rst_n_s;
      rst_n_out <= 1'b0;
      rst_n_oe <= die_reset_req;
      mcu_reset_seen <= ~rst_n_s;
    end
  end

endmodule

`default_nettype wire

// ===== ads_spi_status_asserts.sv
// Port checker for the analog die serial port block.
// Assumes binding to ads_spi_status; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module ads_spi_status_asserts
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic slave_select_n,
  input wire logic miso_oe,
  input wire logic irq_n_out,
  input wire logic irq_n_oe,
  input wire logic rst_n_in,
  input wire logic rst_n_out,
  input wire logic rst_n_oe,
  input wire logic die_reset_req,
  input wire logic mcu_reset_seen,
  input wire logic low_voltage_cond,
  input wire logic hb_overcurrent_cond,
  input wire logic line_event_flag,
  input wire logic wake_event,
  input wire logic [7:0] interrupt_enable_mask
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Serial port, reset pin and interrupt relations
  a_miso_hiz: assert property (slave_select_n [*6] |-> !miso_oe)
    else $error("data out driven while deselected");
  a_oe_start: assert property ($fell(slave_select_n) |->
    ##[2:6] miso_oe)
    else $error("data out not enabled after select");
  a_irq_level: assert property (irq_n_oe |-> !irq_n_out)
    else $error("interrupt drive level wrong");
  a_rst_drive: assert property (die_reset_req |=>
    rst_n_oe && !rst_n_out)
    else $error("reset pin not pulled low");
  a_seen_low: assert property (!rst_n_in [*6] |-> mcu_reset_seen)
    else $error("outside reset not seen");
  a_mask_spare: assert property (
    (interrupt_enable_mask & 8'hc1) == 8'h00)
    else $error("spare mask bits set");
  a_mask_commit: assert property ($changed(interrupt_enable_mask) &&
    interrupt_enable_mask != 8'h00 |->
    slave_select_n && $past(slave_select_n, 2))
    else $error("mask changed inside a frame");
  a_irq_quiet: assert property ((interrupt_enable_mask == 8'h00 &&
    !wake_event && !line_event_flag) [*5] |-> !irq_n_oe)
    else $error("interrupt with nothing enabled");
  a_lv_irq: assert property ((interrupt_enable_mask[3] &&
    low_voltage_cond && rst_n_in) [*8] |-> irq_n_oe)
    else $error("low voltage interrupt missing");
  a_oc_irq: assert property ((interrupt_enable_mask[1] &&
    hb_overcurrent_cond && rst_n_in) [*8] |-> irq_n_oe)
    else $error("overcurrent interrupt missing");
  // Main scenarios reached
  c_frame: cover property ($rose(miso_oe));
  c_irq: cover property ($rose(irq_n_oe));
  c_rst: cover property ($rose(mcu_reset_seen));
endmodule
bind ads_spi_status ads_spi_status_asserts u_ads_spi_status_asserts (.sys_clk,
  .srst, .slave_select_n, .miso_oe, .irq_n_out, .irq_n_oe, .rst_n_in,
  .rst_n_out, .rst_n_oe, .die_reset_req, .mcu_reset_seen, .low_voltage_cond,
  .hb_overcurrent_cond, .line_event_flag, .wake_event, .interrupt_enable_mask);
`default_nettype wire

// ===== ads_spi_status_tb.sv
// Self-checking bench for the analog die serial port block.
// Assumes the master model runs frames at a 125 ns serial clock.
`timescale 1ns/10ps
`default_nettype none
module ads_spi_status_tb;
  logic sys_clk, srst, die_req, mcu_rst;
  logic [7:0] cnd, d, m;
  logic [15:0] q;
  wire logic ss_n, sck, mosi, miso, rst_pin, miso_out, miso_oe, irq_n_out;
  wire logic irq_n_oe, rst_n_out, rst_n_oe, seen;
  wire logic [7:0] mask;
  int fails, tests_run, cyc, i, seed;
  // Pin resolution: tri-state data out, open-drain reset
  assign miso = miso_oe ? miso_out : 1'bz;
  assign rst_pin = !(rst_n_oe || mcu_rst);
  ads_spi_master u_ads_spi_master (.ss_n(ss_n), .sck(sck), .mosi(mosi),
    .miso(miso));
  ads_spi_status u_ads_spi_status (.sys_clk(sys_clk), .srst(srst),
    .slave_select_n(ss_n), .serial_shift_clock(sck), .mosi(mosi),
    .miso_out(miso_out), .miso_oe(miso_oe), .irq_n_out(irq_n_out),
    .irq_n_oe(irq_n_oe), .rst_n_in(rst_pin), .rst_n_out(rst_n_out),
    .rst_n_oe(rst_n_oe), .die_reset_req(die_req), .mcu_reset_seen(seen),
    .low_voltage_cond(cnd[0]), .high_voltage_cond(cnd[1]),
    .hb_overcurrent_cond(cnd[2]), .hvdd_overcurrent_cond(cnd[3]),
    .high_temp_cond(cnd[4]), .lin_current_limit(cnd[5]),
    .line_event_flag(cnd[6]), .wake_event(cnd[7]),
    .interrupt_enable_mask(mask));
  // Clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Frame word: address, direction, parity, spare, data
  function automatic logic [15:0] fr(input logic [4:0] a, input logic rw,
    input logic [7:0] v);
    fr = {a, rw, ^{rw, a}, 1'b0, v};
  endfunction
  task automatic tx(input logic [4:0] a, input logic rw, input logic [7:0] v);
    u_ads_spi_master.xfer(fr(a, rw, v), 16, q);
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic setc(input int k, input logic v);
    @(posedge sys_clk) #1 cnd[k] = v;
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      fails++;
      close_out;
    end
  end
  // Main sequence
  initial
  begin
    seed = 32'h4dee;
    srst = 1'b1;
    die_req = 1'b0;
    mcu_rst = 1'b0;
    cnd = 8'h00;
    repeat (16) @(posedge sys_clk);
    #1 srst = 1'b0;
    repeat (8) @(posedge sys_clk);
    tx(5'h04, 1'b1, 8'h00); chk(q, 16'h0000);
    tx(5'h1f, 1'b1, 8'h00); chk(q, 16'h0000);
    m = 8'h00;
    for (i = 0; i < 6; i++)
    begin
      d = 8'($random(seed));
      tx(5'h04, 1'b0, d); chk(q, {8'h00, m});
      m = d & 8'h3e;
      chk(16'(mask), 16'(m));
      tx(5'h04, 1'b1, ~d); chk(q, {8'h00, m});
    end
    u_ads_spi_master.xfer(fr(5'h04, 1'b0, ~m) ^ 16'h0200, 16, q);
    repeat (8) @(posedge sys_clk);
    chk(16'(mask), 16'(m));
    for (i = 15; i < 18; i += 2)
    begin
      u_ads_spi_master.xfer(fr(5'h04, 1'b0, ~m), i, q);
      repeat (8) @(posedge sys_clk);
      chk(16'(mask), 16'(m));
    end
    tx(5'h04, 1'b0, 8'h0c);
    for (i = 0; i < 2; i++)
    begin
      setc(i, 1'b1);
      tx(5'h0c, 1'b0, 8'h08 >> i); chk(16'(irq_n_oe), 16'h1);
      setc(i, 1'b0);
      tx(5'h0c, 1'b0, 8'h00);
      tx(5'h0c, 1'b1, 8'h00); chk(q, 16'h0808 >> i);
      tx(5'h0c, 1'b0, 8'h08 >> i);
      tx(5'h0c, 1'b1, 8'h00); chk(q, 16'h0000);
      chk(16'(irq_n_oe), 16'h0);
    end
    tx(5'h04, 1'b0, 8'h02);
    setc(2, 1'b1);
    setc(2, 1'b0);
    tx(5'h02, 1'b1, 8'h00); chk(q, 16'h0201);
    chk(16'(irq_n_oe), 16'h1);
    tx(5'h0c, 1'b0, 8'h02);
    tx(5'h02, 1'b1, 8'h00); chk(q, 16'h0000);
    tx(5'h04, 1'b0, 8'h20);
    setc(6, 1'b1); chk(16'(irq_n_oe), 16'h1);
    setc(6, 1'b0); chk(16'(irq_n_oe), 16'h0);
    setc(7, 1'b1); chk({irq_n_out, irq_n_oe}, 16'h1);
    setc(7, 1'b0);
    @(posedge sys_clk) #1 die_req = 1'b1;
    repeat (8) @(posedge sys_clk);
    chk({rst_n_out, rst_n_oe, rst_pin, seen}, 16'h5);
    #1 die_req = 1'b0;
    repeat (8) @(posedge sys_clk);
    tx(5'h04, 1'b0, 8'h3e);
    #1 mcu_rst = 1'b1;
    repeat (8) @(posedge sys_clk);
    chk(16'(seen), 16'h1);
    #1 mcu_rst = 1'b0;
    repeat (8) @(posedge sys_clk);
    chk(16'(mask), 16'h0000);
    close_out;
  end
endmodule
`default_nettype wire

// ===== ads_sync.v
// Two-stage synchroniser bank for inputs from outside sys_clk.
// Assumes a free-running sys_clk; inputs may change at any time.
`timescale 1ns/10ps
`default_nettype none

module ads_sync
#(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
)
(
  input wire sys_clk,
  input wire srst,
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  genvar i;

  // One two-flop chain per bit; stage one feeds stage two only
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
      reg stage1;
      reg stage2;
      always @(posedge sys_clk)
      begin
        // Reset to the pin's idle level so no false event follows reset
        if (srst)
        begin
          stage1 <= RST_VAL[i];
          stage2 <= RST_VAL[i];
        end
        else
        begin
          stage1 <= async_in[i];
          stage2 <= stage1;
        end
      end
      assign sync_out[i] = stage2;
    end
  endgenerate

endmodule

`default_nettype wire
